// file: hdl/bcfg_pkg.sv
// Constants, field layout and state codes of the boot-configuration access block
`default_nettype none
package bcfg_pkg;
  // Command codes
  localparam logic [7:0] BOOT_CFG_READ_CMD   = 8'h14;
  localparam logic [7:0] BOOT_CFG_WRITE_CMD  = 8'h15;
  localparam logic [7:0] WRITE_LATCH_ARM_CMD = 8'h06;
  localparam logic [7:0] STATUS_READ_CMD     = 8'h05;
  // Word and phase sizes
  localparam logic [5:0] CMD_BITS  = 6'h08;
  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam logic [5:0] OVER_BITS = 6'h21;    // Saturation mark past a word
  localparam logic [5:0] STEP_QUAD = 6'h04;
  localparam logic [5:0] STEP_ONE  = 6'h01;
  // Field positions inside the boot-configuration word
  localparam int ENABLE_BIT = 0;
  localparam int DELAY_LSB  = 1;
  localparam int DELAY_MSB  = 4;
  localparam int ADDR_LSB   = 5;
  localparam int ADDR_MSB   = 31;
  // Value the storage holds after a power-on load
  localparam logic [31:0] BOOT_CFG_ERASED = 32'h0000_0000;
  // Internal write cycle time
  localparam int WRITE_CYCLE_NS = 5000;
  localparam int CLK_PERIOD_NS  = 10;
  localparam logic [9:0] WRITE_CYCLES =
    10'((WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Command decoder states, one-hot
  typedef enum logic [4:0] {
    ST_CMD = 5'b0_0001,
    ST_RD  = 5'b0_0010,
    ST_SR  = 5'b0_0100,
    ST_WR  = 5'b0_1000,
    ST_IGN = 5'b1_0000
  } bcfg_state_t;
endpackage
`default_nettype wire

// file: hdl/bcfg_access.sv
// Serial command logic for reading and writing the boot-configuration register
// Contract
// - Command 14h makes the device shift out the whole 32-bit register.
// - The register goes out lowest byte first, each byte MSB first.
// - With select held low the 32-bit word repeats without end.
// - Command 15h is only accepted after write-enable set the latch flag.
// - Select rising anywhere but right after bit 32 discards the write.
// - The internal write cycle starts when select rises on a good frame.
// - The busy flag is 1 for the whole write cycle, 0 when it ends.
// - The latch flag clears when the write cycle completes.
// - The register is kept across resets as nonvolatile storage.
// - The register holds a start address, a 4-bit delay and an enable.
`timescale 1ns/10ps
`default_nettype none
module bcfg_access (
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        POR,
  input  wire logic        SCK,
  input  wire logic        CS_N,
  input  wire logic [3:0]  IO_IN,
  output logic      [3:0]  IO_OUT,
  output logic      [3:0]  IO_OE,
  input  wire logic        QUAD_COMMAND_MODE,
  output logic      [26:0] BOOT_START_ADDRESS,
  output logic      [3:0]  BOOT_START_DELAY,
  output logic             BOOT_FEATURE_ENABLE,
  output logic             WRITE_IN_PROGRESS_FLAG,
  output logic             WRITE_LATCH_FLAG
);

  // Byte order swap: the wire carries byte 0 first, MSB first
  function automatic logic [31:0] byte_swap(input logic [31:0] w);
    byte_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  logic [2:0]  sck_s;
  logic [2:0]  cs_s;
  logic [3:0]  io_s1;
  logic [3:0]  io_s2;
  logic        sck_rise;
  logic        sck_fall;
  logic        cs_rise;
  logic        cs_low;
  logic [5:0]  step;
  logic [5:0]  cnt_r;
  logic [5:0]  cnt_nxt;
  logic [7:0]  cmd_nxt;
  logic [6:0]  cmd_r;
  logic [31:0] wdat_r;
  logic [31:0] tx_r;
  logic [5:0]  tx_cnt_r;
  logic [31:0] cfg_r;
  logic [31:0] new_r;
  logic        wip_r;
  logic        wel_r;
  logic [9:0]  timer_r;
  logic        good_frame;
  bcfg_pkg::bcfg_state_t st_r;

  // Pins come from another clock domain; stage one feeds stage two only
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sck_s <= 3'h0;
      cs_s  <= 3'h7;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
    end else if (CE) begin
      sck_s <= {sck_s[1:0], SCK};
      cs_s  <= {cs_s[1:0], CS_N};
      io_s1 <= IO_IN;
      io_s2 <= io_s1;
    end
  end

  // Edge detection runs on the second and third stages only
  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign sck_fall = ~sck_s[1] & sck_s[2];
  assign cs_rise  = cs_s[1] & ~cs_s[2];
  assign cs_low   = ~cs_s[1];
  assign step     = QUAD_COMMAND_MODE ? bcfg_pkg::STEP_QUAD
                                      : bcfg_pkg::STEP_ONE;
  assign cnt_nxt  = cnt_r + step;
  assign cmd_nxt  = QUAD_COMMAND_MODE ? {cmd_r[3:0], io_s2}
                                      : {cmd_r[6:0], io_s2[0]};
  assign good_frame = (st_r == bcfg_pkg::ST_WR) &&
                      (cnt_r == bcfg_pkg::WORD_BITS);

  // Command decode and write data capture on the host's rising edges
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_r   <= bcfg_pkg::ST_CMD;
      cnt_r  <= 6'h00;
      cmd_r  <= 7'h00;
      wdat_r <= 32'h0000_0000;
    end else if (CE) begin
      if (!cs_low) begin
        st_r  <= bcfg_pkg::ST_CMD;
        cnt_r <= 6'h00;
      end else if (sck_rise) begin
        case (st_r)
          bcfg_pkg::ST_CMD: begin
            cmd_r <= cmd_nxt[6:0];
            if (cnt_nxt == bcfg_pkg::CMD_BITS) begin
              cnt_r <= 6'h00;
              case (cmd_nxt)
                bcfg_pkg::BOOT_CFG_READ_CMD: st_r <= bcfg_pkg::ST_RD;
                bcfg_pkg::STATUS_READ_CMD:   st_r <= bcfg_pkg::ST_SR;
                bcfg_pkg::BOOT_CFG_WRITE_CMD: begin
                  // Refused without an armed latch or while busy
                  st_r <= (wel_r && !wip_r) ? bcfg_pkg::ST_WR
                                            : bcfg_pkg::ST_IGN;
                end
                default: st_r <= bcfg_pkg::ST_IGN;
              endcase
            end else begin
              cnt_r <= cnt_nxt;
            end
          end
          bcfg_pkg::ST_WR: begin
            // MSB-first shift gives byte 0 on top; swapped at commit
            wdat_r <= QUAD_COMMAND_MODE ? {wdat_r[27:0], io_s2}
                                        : {wdat_r[30:0], io_s2[0]};
            // Count saturates past 32 so over-long frames stay bad
            cnt_r <= (cnt_nxt > bcfg_pkg::WORD_BITS) ? bcfg_pkg::OVER_BITS
                                                     : cnt_nxt;
          end
          default: cnt_r <= cnt_r;
        endcase
      end
    end
  end

  // Read data launched on falling edges, reloaded every 32 bits
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      tx_r     <= 32'h0000_0000;
      tx_cnt_r <= 6'h00;
    end else if (CE) begin
      if (!cs_low) begin
        tx_cnt_r <= 6'h00;
      end else if (sck_fall && (st_r == bcfg_pkg::ST_RD ||
                                st_r == bcfg_pkg::ST_SR)) begin
        if (tx_cnt_r == 6'h00 || tx_cnt_r == bcfg_pkg::WORD_BITS) begin
          tx_r <= (st_r == bcfg_pkg::ST_RD) ? byte_swap(cfg_r)
                  : {4{6'h00, wel_r, wip_r}};
          tx_cnt_r <= step;
        end else begin
          tx_r     <= QUAD_COMMAND_MODE ? {tx_r[27:0], 4'h0}
                                        : {tx_r[30:0], 1'b0};
          tx_cnt_r <= tx_cnt_r + step;
        end
      end
    end
  end

  // Output drive: one line in single mode, all four in quad mode
  always_comb begin
    IO_OUT = QUAD_COMMAND_MODE ? tx_r[31:28] : {2'b00, tx_r[31], 1'b0};
    IO_OE  = 4'h0;
    if (cs_low && tx_cnt_r != 6'h00) begin
      IO_OE = QUAD_COMMAND_MODE ? 4'hF : 4'h2;
    end
  end

  // Latch flag, busy flag and write timer
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wel_r   <= 1'b0;
      wip_r   <= 1'b0;
      timer_r <= 10'h000;
      new_r   <= 32'h0000_0000;
    end else if (CE) begin
      if (wip_r) begin
        if (timer_r == 10'h001) begin
          wip_r <= 1'b0;
          wel_r <= 1'b0;
        end
        timer_r <= timer_r - 10'h001;
      end else if (cs_rise && good_frame) begin
        wip_r   <= 1'b1;
        timer_r <= bcfg_pkg::WRITE_CYCLES;
        new_r   <= byte_swap(wdat_r);
      end else if (sck_rise && cs_low && st_r == bcfg_pkg::ST_CMD &&
                   cnt_nxt == bcfg_pkg::CMD_BITS &&
                   cmd_nxt == bcfg_pkg::WRITE_LATCH_ARM_CMD) begin
        wel_r <= 1'b1;
      end
    end
  end

  // Storage ignores RST so the content survives resets; POR loads it
  always_ff @(posedge REF_CLK) begin
    if (POR) begin
      cfg_r <= bcfg_pkg::BOOT_CFG_ERASED;
    end else if (CE && !RST && wip_r && timer_r == 10'h001) begin
      cfg_r <= new_r;
    end
  end

  // Field view of the stored word
  always_ff @(posedge REF_CLK) begin
    if (POR) begin
      BOOT_START_ADDRESS  <= 27'h000_0000;
      BOOT_START_DELAY    <= 4'h0;
      BOOT_FEATURE_ENABLE <= 1'b0;
    end else if (CE) begin
      BOOT_START_ADDRESS  <= cfg_r[bcfg_pkg::ADDR_MSB:bcfg_pkg::ADDR_LSB];
      BOOT_START_DELAY    <= cfg_r[bcfg_pkg::DELAY_MSB:bcfg_pkg::DELAY_LSB];
      BOOT_FEATURE_ENABLE <= cfg_r[bcfg_pkg::ENABLE_BIT];
    end
  end

  assign WRITE_IN_PROGRESS_FLAG = wip_r;
  assign WRITE_LATCH_FLAG       = wel_r;

  // Checks; the read and write-start checks gate on CE, the rest hold with CE low too
  a_rd_first_byte: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (CE && cs_low && sck_fall && st_r == bcfg_pkg::ST_RD &&
     tx_cnt_r == 6'h00)
    |=> tx_r[31:24] == cfg_r[7:0])
    else $error("read word does not start with low byte");
  a_rd_word_repeat: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (CE && cs_low && sck_fall && st_r == bcfg_pkg::ST_RD &&
     tx_cnt_r == bcfg_pkg::WORD_BITS)
    |=> tx_r == byte_swap(cfg_r) && tx_cnt_r == step)
    else $error("read word not reloaded after 32 bits");
  a_wr_needs_latch: assert property (
    @(posedge REF_CLK) disable iff (RST)
    $changed(st_r) && st_r == bcfg_pkg::ST_WR
    |-> $past(wel_r) && !$past(wip_r))
    else $error("write accepted without latch flag");
  a_wr_cycle_start: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (CE && cs_rise && good_frame && !wip_r)
    |=> wip_r && timer_r == bcfg_pkg::WRITE_CYCLES)
    else $error("write cycle did not start on select rise");
  a_wr_bad_frame: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (cs_rise && !good_frame && !wip_r) |=> !wip_r)
    else $error("badly framed write was executed");
  a_busy_hold: assert property (
    @(posedge REF_CLK) disable iff (RST)
    $rose(wip_r) |-> wip_r[*8])
    else $error("busy flag dropped early");
  a_latch_clear: assert property (
    @(posedge REF_CLK) disable iff (RST)
    $fell(wip_r) |-> !wel_r && cfg_r == $past(new_r))
    else $error("latch not cleared or word not stored at cycle end");
  a_nv_keep: assert property (
    @(posedge REF_CLK) disable iff (POR)
    RST |=> $stable(cfg_r))
    else $error("stored word changed under reset");
  a_quad_drive: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (QUAD_COMMAND_MODE && cs_low && tx_cnt_r != 6'h00) |-> IO_OE == 4'hF)
    else $error("quad read not driving all lines");
  a_drive_in_read: assert property (
    @(posedge REF_CLK) disable iff (RST)
    (IO_OE != 4'h0) |-> cs_low && (st_r == bcfg_pkg::ST_RD ||
                                    st_r == bcfg_pkg::ST_SR))
    else $error("data lines driven outside a read");

endmodule // bcfg_access
`default_nettype wire

// file: testbench/bcfg_host.sv
// Host controller model that frames serial commands to the block
`timescale 1ns/10ps
`default_nettype none
module bcfg_host (
  input  wire logic       ref_clk,
  input  wire logic [3:0] io_line,
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] drv,
  output logic            quad
);
  // Idle pins; the link clock stands still outside frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    drv = 4'h0;
    quad = 1'b0;
  end
  // Half link period, 80 ns, counted on falling edges
  task automatic half();
    repeat (8) @(negedge ref_clk);
  endtask
  // Code then nd data bits, sent (rx=0) or sampled at each clock rise
  task automatic frame(input logic q, input logic [7:0] code,
    input logic [31:0] wd, input int nd, input logic rx,
    output logic [63:0] rd);
    logic [39:0] s;
    int          step;
    s = {code, wd[7:0], wd[15:8], wd[23:16], wd[31:24]};
    step = q ? 4 : 1;
    rd = '0;
    quad = q;
    cs_n = 1'b0;
    for (int i = 0; i < 8 + nd; i += step) begin
      // Released lines toggle so a stale value never looks valid
      if (rx && i >= 8) drv = ~drv;
      else drv = q ? s[39:36] : {~drv[3:1], s[39]};
      s = s << step;
      half();
      sck = 1'b1;
      if (i >= 8) rd = q ? {rd[59:0], io_line} : {rd[62:0], io_line[1]};
      half();
      sck = 1'b0;
    end
    half();
    cs_n = 1'b1; // Select rises only after the last bit is latched
    repeat (8) @(negedge ref_clk);
  endtask
endmodule // bcfg_host
`default_nettype wire

// file: testbench/bcfg_access_bench.sv
// Self-checking bench for the boot-configuration access block
`timescale 1ns/10ps
`default_nettype none
module bcfg_access_bench;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        por = 1'b1;
  logic        sck, cs_n, quad, ena, busy, latch;
  logic [3:0]  drv, io_out, io_oe, io_w, dly;
  logic [26:0] addr;
  logic [31:0] seed = 32'h4a13;
  logic [31:0] w, m_word;
  logic        m_latch;
  logic [63:0] rd;
  logic [63:0] exp_rd;
  logic        ce = 1'b1;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Wire level: the block wins on the lines it enables
  assign io_w = (io_oe & io_out) | (~io_oe & drv);
  bcfg_host host (.ref_clk(ref_clk), .io_line(io_w), .sck(sck),
    .cs_n(cs_n), .drv(drv), .quad(quad));
  bcfg_access dut (.REF_CLK(ref_clk), .RST(rst), .CE(ce), .POR(por),
    .SCK(sck), .CS_N(cs_n), .IO_IN(io_w), .IO_OUT(io_out), .IO_OE(io_oe),
    .QUAD_COMMAND_MODE(quad), .BOOT_START_ADDRESS(addr),
    .BOOT_START_DELAY(dly), .BOOT_FEATURE_ENABLE(ena),
    .WRITE_IN_PROGRESS_FLAG(busy), .WRITE_LATCH_FLAG(latch));
  task automatic chk(input string nm, input logic [63:0] e,
    input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Fields and flags against the model, busy idle
  task automatic chk_state();
    chk("state", {30'h0, m_word, m_latch, 1'b0},
      {30'h0, addr, dly, ena, latch, busy});
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog well past the expected run of some 7200 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    por = 1'b0;
    m_word = 32'h0000_0000;
    m_latch = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk_state();
    for (int q = 0; q < 2; q++) begin
      w = $random(seed);
      host.frame(1'(q), 8'h15, w, 32, 1'b0, rd);
      chk_state();
      host.frame(1'(q), 8'h06, 32'h0, 0, 1'b0, rd);
      m_latch = 1'b1;
      chk_state();
      host.frame(1'(q), 8'h15, w, 28, 1'b0, rd);
      chk_state();
      // Too long a frame must be dropped as well
      host.frame(1'(q), 8'h15, w, 36, 1'b0, rd);
      chk_state();
      host.frame(1'(q), 8'h15, w, 32, 1'b0, rd);
      chk("busy", 64'h1, {63'h0, busy});
      host.frame(1'(q), 8'h05, 32'h0, 8, 1'b1, rd);
      chk("status", {62'h0, m_latch, 1'b1}, rd);
      // Clock enable low freezes the write timer past its full length
      ce = 1'b0;
      repeat (600) @(negedge ref_clk);
      chk("frozen", 64'h1, {63'h0, busy});
      ce = 1'b1;
      for (int k = 0; k < 600 && busy !== 1'b0; k++) @(negedge ref_clk);
      m_word = w;
      m_latch = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk_state();
      host.frame(1'(q), 8'h14, 32'h0, 64, 1'b1, rd);
      exp_rd = {2{m_word[7:0], m_word[15:8], m_word[23:16], m_word[31:24]}};
      chk("read", exp_rd, rd);
    end
    // Reset in mid-run must not lose the stored word
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk_state();
    test_done();
  end
endmodule // bcfg_access_bench
`default_nettype wire
